// *** verilog/pdio_pkg.sv ***
/*
 * pdio_pkg: constants and carrier types for the parallel i/o port.
 * assumes a 250 MHz aclk and a 32-bit axi4-lite register bus.
 */
package pdio_pkg;
    // register byte offsets
    localparam logic [3:0] STATUS_OFFSET = 4'h0;
    localparam logic [3:0] INPUT_OFFSET = 4'h4;
    localparam logic [3:0] OUTPUT_OFFSET = 4'h8;
    localparam logic [3:0] CONFIG_OFFSET = 4'hc;
    // status field positions
    localparam int RELAY1_BIT = 0;
    localparam int MAINT1_BIT = 5;
    localparam int IN_ENABLE_BIT = 6;
    localparam int IN_FLAG_BIT = 7;
    localparam int RELAY2_BIT = 8;
    localparam int MAINT2_BIT = 13;
    localparam int OUT_ENABLE_BIT = 14;
    localparam int OUT_FLAG_BIT = 15;
    // bits that software may write in status
    localparam logic [15:0] STATUS_WRITE_MASK = 16'h6161;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    // pulse timing
    localparam int CLOCK_MHZ = 250;
    localparam int PULSE_NS = 1000;
    localparam int PULSE_CYCLES = (PULSE_NS * CLOCK_MHZ) / 1000;
    localparam int PULSE_COUNT_WIDTH = 9;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // static strap configuration of the input path
    typedef struct packed {
        logic [15:0] stimulus_bits; // 1: bit may raise input interrupt
        logic [1:0] true_low; // bits 15,14: 1 when ground is true level
    } pdio_strap_t;

    // signals from the external device
    typedef struct packed {
        logic [15:0] data;
        logic data_valid_strobe;
        logic data_taken_strobe;
    } pdio_ext_in_t;
endpackage

// *** verilog/pdio_pulse.sv ***
/*
 * pdio_pulse: fixed-width pulse stretcher for handshake lines.
 * assumes a one-cycle trigger synchronous to aclk.
 */
`timescale 1ns/10ps
`default_nettype none
module pdio_pulse
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // trigger and stretched pulse
    input wire logic trigger,
    output logic pulse
);
    localparam int COUNT_W = pdio_pkg::PULSE_COUNT_WIDTH;
    logic [COUNT_W-1:0] count;

    // retrigger restarts the full width
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count <= '0;
        else if (trigger)
            count <= COUNT_W'(pdio_pkg::PULSE_CYCLES);
        else if (count != '0)
            count <= count - 1'b1;
    end

    assign pulse = (count != '0);
endmodule
`default_nettype wire

// *** verilog/pdio_port.sv ***
/*
 * pdio_port: 16-bit parallel input/output port with status,
 * input and output registers behind an axi4-lite slave.
 * assumes external inputs synchronous to aclk and static strap inputs.
 */
`timescale 1ns/10ps
`default_nettype none
module pdio_port
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // static configuration
    input wire pdio_pkg::pdio_strap_t strap,
    // external device side
    input wire pdio_pkg::pdio_ext_in_t ext_in,
    output logic [15:0] ext_data_out,
    output logic out_data_valid_pulse,
    output logic data_taken_pulse,
    output logic relay1,
    output logic relay2,
    // interrupt requests and acknowledges
    output logic input_irq,
    output logic output_irq,
    input wire logic input_irq_ack,
    input wire logic output_irq_ack,
    // bus control handshakes
    output logic slave_response_enable,
    output logic input_read_strobe
);
    logic [15:0] status;
    logic [15:0] in_reg;
    logic [15:0] out_reg;
    logic [15:0] prev_level;
    logic [15:0] level;
    logic [15:0] falls;
    logic have_aw;
    logic have_w;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic do_read;
    logic status_load_hi;
    logic status_load_lo;
    logic input_clear_hi;
    logic input_clear_lo;
    logic output_load_hi;
    logic output_load_lo;
    logic [15:0] clear_mask;
    logic stim_event;
    logic in_flag_set;
    logic out_flag_set;
    logic [15:0] next_status;
    logic [31:0] next_rdata;
    logic read_hit;
    logic write_hit;

    // software-writable bits of status; flags 7 and 15 stay hardware-only
    localparam logic [15:0] STATUS_WRITE_MASK_L = pdio_pkg::STATUS_WRITE_MASK;

    // true level of each line: bits 15,14 may be ground-true, rest high-true
    always_comb
    begin
        level = ext_in.data;
        level[15] = ext_in.data[15] ^ strap.true_low[1];
        level[14] = ext_in.data[14] ^ strap.true_low[0];
    end

    // one-cycle falling edge of the true level sets the latch
    assign falls = prev_level & ~level;

    // previous true level; reset low so that a line idling false at release
    // shows no false edge, a fall needs a seen-true cycle first
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            prev_level <= pdio_pkg::DATA_RESET;
        else
            prev_level <= level;
    end

    // axi write channels are accepted independently, then committed together
    assign s_axi_awready = !have_aw && !s_axi_bvalid;
    assign s_axi_wready = !have_w && !s_axi_bvalid;
    assign do_write = have_aw && have_w && !s_axi_bvalid;

    // write address holding register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            have_aw <= 1'b0;
            aw_addr <= 4'h0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            have_aw <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (do_write)
            have_aw <= 1'b0;
    end

    // write data and strobe holding register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            have_w <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            have_w <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
            have_w <= 1'b0;
    end

    // write decode into byte load strobes
    always_comb
    begin
        status_load_hi = do_write && aw_addr == pdio_pkg::STATUS_OFFSET && w_strb[1];
        status_load_lo = do_write && aw_addr == pdio_pkg::STATUS_OFFSET && w_strb[0];
        input_clear_hi = do_write && aw_addr == pdio_pkg::INPUT_OFFSET && w_strb[1];
        input_clear_lo = do_write && aw_addr == pdio_pkg::INPUT_OFFSET && w_strb[0];
        output_load_hi = do_write && aw_addr == pdio_pkg::OUTPUT_OFFSET && w_strb[1];
        output_load_lo = do_write && aw_addr == pdio_pkg::OUTPUT_OFFSET && w_strb[0];
        write_hit = aw_addr == pdio_pkg::STATUS_OFFSET || aw_addr == pdio_pkg::INPUT_OFFSET
            || aw_addr == pdio_pkg::OUTPUT_OFFSET || aw_addr == pdio_pkg::CONFIG_OFFSET;
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pdio_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= write_hit ? pdio_pkg::RESP_OKAY : pdio_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // input register: edges set, written ones clear, set wins over clear
    always_comb
    begin
        clear_mask = {input_clear_hi ? w_data[15:8] : 8'h00,
            input_clear_lo ? w_data[7:0] : 8'h00};
    end

    // a bit falling in the cycle of its clear stays set
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            in_reg <= pdio_pkg::DATA_RESET;
        else
            in_reg <= (in_reg & ~clear_mask) | falls;
    end

    // output register loaded bytewise and shown to the device
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            out_reg <= pdio_pkg::DATA_RESET;
        else
        begin
            if (output_load_hi)
                out_reg[15:8] <= w_data[15:8];
            if (output_load_lo)
                out_reg[7:0] <= w_data[7:0];
        end
    end

    // the device sees the register directly, no extra buffer stage
    assign ext_data_out = out_reg;

    // input flag sources: falls on stimulus lines and the external strobe; the maintenance bit sets no flag
    assign stim_event = |(falls & strap.stimulus_bits);
    assign in_flag_set = stim_event || ext_in.data_valid_strobe;
    assign out_flag_set = ext_in.data_taken_strobe;

    // status register update; hardware sets win over software writes
    always_comb
    begin
        next_status = status;
        if (status_load_hi)
            next_status[15:8] = (status[15:8] & ~STATUS_WRITE_MASK_L[15:8])
                | (w_data[15:8] & STATUS_WRITE_MASK_L[15:8]);
        if (status_load_lo)
            next_status[7:0] = (status[7:0] & ~STATUS_WRITE_MASK_L[7:0])
                | (w_data[7:0] & STATUS_WRITE_MASK_L[7:0]);
        if (in_flag_set)
            next_status[pdio_pkg::IN_FLAG_BIT] = 1'b1;
        if (out_flag_set)
            next_status[pdio_pkg::OUT_FLAG_BIT] = 1'b1;
        if (input_irq_ack)
            next_status[pdio_pkg::IN_ENABLE_BIT] = 1'b0;
    end

    // status register, cleared only by reset in its flag bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            status <= pdio_pkg::STATUS_RESET;
        else
            status <= next_status;
    end

    // relay drivers follow their status bits
    assign relay1 = status[pdio_pkg::RELAY1_BIT];
    assign relay2 = status[pdio_pkg::RELAY2_BIT];

    // interrupt requests: flag set or maintenance force, gated by enable; ack clears unless a set comes in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            input_irq <= 1'b0;
        else if ((in_flag_set || status[pdio_pkg::MAINT1_BIT])
            && status[pdio_pkg::IN_ENABLE_BIT])
            input_irq <= 1'b1;
        else if (input_irq_ack)
            input_irq <= 1'b0;
    end

    // output request: same scheme as input, but ack leaves the enable alone
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            output_irq <= 1'b0;
        else if ((out_flag_set || status[pdio_pkg::MAINT2_BIT])
            && status[pdio_pkg::OUT_ENABLE_BIT])
            output_irq <= 1'b1;
        else if (output_irq_ack)
            output_irq <= 1'b0;
    end

    // read path: one read at a time, data registered
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        read_hit = 1'b1;
        case (s_axi_araddr)
            pdio_pkg::STATUS_OFFSET: next_rdata[15:0] = status;
            pdio_pkg::INPUT_OFFSET: next_rdata[15:0] = in_reg;
            pdio_pkg::OUTPUT_OFFSET: next_rdata[15:0] = out_reg;
            pdio_pkg::CONFIG_OFFSET: next_rdata[17:0] = strap;
            default: read_hit = 1'b0;
        endcase
    end

    // read answer registered; rvalid holds until rready is seen
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pdio_pkg::RESP_OKAY;
        end
        else if (do_read)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= read_hit ? pdio_pkg::RESP_OKAY : pdio_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // bus control handshakes, one cycle each
    assign input_read_strobe = do_read && s_axi_araddr == pdio_pkg::INPUT_OFFSET;
    assign slave_response_enable = (do_read && read_hit) || (do_write && write_hit);

    // one-microsecond pulses to the external device
    pdio_pulse u_taken_pulse
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .trigger(input_read_strobe),
        .pulse(data_taken_pulse)
    );

    pdio_pulse u_valid_pulse
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .trigger(output_load_hi || output_load_lo),
        .pulse(out_data_valid_pulse)
    );
endmodule
`default_nettype wire

// *** verif/pdio_ext_model.sv ***
/*
 * pdio_ext_model: external laboratory device facing the port's parallel lines.
 * assumes aclk of the port; data lines idle high, as if pulled up.
 */
`timescale 1ns/10ps
`default_nettype none
module pdio_ext_model
(
    // clock
    input wire logic aclk,
    // output word and its new-data pulse
    input wire logic [15:0] ext_data_out,
    input wire logic out_data_valid_pulse,
    // lines driven toward the port
    output var pdio_pkg::pdio_ext_in_t ext_in
);
    int delay = 40;
    int wait_n = 0;
    logic [15:0] got;
    logic last = 1'b0;
    initial ext_in = {16'hffff, 2'h0};
    // take the word on the pulse's rising edge, answer after delay cycles
    always @(posedge aclk)
    begin
        last <= out_data_valid_pulse;
        ext_in.data_taken_strobe <= (wait_n == 1);
        if (out_data_valid_pulse && !last)
        begin
            got <= ext_data_out;
            wait_n <= delay;
        end
        else if (wait_n != 0)
            wait_n <= wait_n - 1;
    end
    // chosen lines fall, then the new-data strobe pulses when asked
    task automatic send(input logic [15:0] w, input logic s);
        @(posedge aclk);
        ext_in.data <= ~w;
        @(posedge aclk);
        ext_in.data_valid_strobe <= s;
        @(posedge aclk);
        ext_in.data_valid_strobe <= 1'b0;
        ext_in.data <= 16'hffff;
    endtask
endmodule
`default_nettype wire

// *** verif/pdio_port_asserts.sv ***
/*
 * pdio_port_asserts: pin timing checks for pdio_port.
 * assumes it is bound into pdio_port and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none
module pdio_port_asserts
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus pins
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    // device side pins
    input wire logic [15:0] ext_data_out,
    input wire logic out_data_valid_pulse,
    input wire logic data_taken_pulse,
    input wire logic input_irq,
    input wire logic output_irq,
    input wire logic output_irq_ack,
    input wire logic slave_response_enable,
    input wire logic input_read_strobe
);
    logic [8:0] out_len;
    logic [8:0] in_len;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // run lengths of the two stretched pulses
    always_ff @(posedge aclk)
    begin
        out_len <= out_data_valid_pulse ? out_len + 9'h001 : 9'h000;
        in_len <= data_taken_pulse ? in_len + 9'h001 : 9'h000;
    end
    a_read_strobe: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == pdio_pkg::INPUT_OFFSET
        |-> input_read_strobe)
        else $error("input read strobe missing");
    a_taken_start: assert property (
        input_read_strobe |=> data_taken_pulse) else $error("taken pulse late");
    a_taken_len: assert property (
        $fell(data_taken_pulse) |-> in_len == 9'(pdio_pkg::PULSE_CYCLES))
        else $error("taken pulse length");
    a_out_start: assert property (
        $rose(out_data_valid_pulse) |-> $past(slave_response_enable))
        else $error("new-data pulse without load");
    a_out_len: assert property (
        $fell(out_data_valid_pulse) |-> out_len == 9'(pdio_pkg::PULSE_CYCLES))
        else $error("new-data length");
    a_resp_enable: assert property (
        slave_response_enable |=> s_axi_bvalid || s_axi_rvalid) else $error("no answer");
    a_out_hold: assert property (
        !$stable(ext_data_out) |-> $past(slave_response_enable)) else $error("output moved");
    a_out_ack: assert property (
        output_irq_ack |=> !output_irq) else $error("output irq kept");
    a_reset_clear: assert property (disable iff (1'b0)
        !aresetn |=> ext_data_out == 16'h0000 && !input_irq && !output_irq)
        else $error("reset left state");
endmodule
bind pdio_port pdio_port_asserts i_asserts (.aclk, .aresetn, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_rvalid, .ext_data_out,
    .out_data_valid_pulse, .data_taken_pulse, .input_irq, .output_irq,
    .output_irq_ack, .slave_response_enable, .input_read_strobe);
`default_nettype wire

// *** verif/pdio_port_test.sv ***
/*
 * pdio_port_test: self-checking bench for pdio_port with an external device model.
 * assumes the package offsets 0x0, 0x4, 0x8, 0xc and 250-cycle pulses.
 */
`timescale 1ns/10ps
`default_nettype none
module pdio_port_test;
    typedef struct packed {
        logic w;
        logic [3:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [31:0] e;
        logic [1:0] r;
    } pdio_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, input_irq_ack = 0, output_irq_ack = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic out_data_valid_pulse, data_taken_pulse, relay1, relay2, input_irq, output_irq;
    logic slave_response_enable, input_read_strobe;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [15:0] ext_data_out;
    pdio_pkg::pdio_strap_t strap = {16'hffff, 2'h0};
    pdio_pkg::pdio_ext_in_t ext_in;
    int err_count = 0;
    int n_checks = 0;
    // bus cases: write flag, address, data, strobes, read data, response
    pdio_row_t rows [15] = '{
        '{0, 4'h0, 32'h0, 4'h0, 32'h0, 2'h0}, '{1, 4'h0, 32'h41, 4'h1, 32'h0, 2'h0},
        '{0, 4'h0, 32'h0, 4'h0, 32'h41, 2'h0}, '{1, 4'h0, 32'h41ff, 4'h2, 32'h0, 2'h0},
        '{0, 4'h0, 32'h0, 4'h0, 32'h4141, 2'h0}, '{1, 4'h8, 32'h1234abcd, 4'h3, 32'h0, 2'h0},
        '{0, 4'h8, 32'h0, 4'h0, 32'habcd, 2'h0}, '{1, 4'h8, 32'h5533, 4'h2, 32'h0, 2'h0},
        '{0, 4'h8, 32'h0, 4'h0, 32'h55cd, 2'h0}, '{1, 4'h8, 32'h77, 4'h1, 32'h0, 2'h0},
        '{0, 4'h8, 32'h0, 4'h0, 32'h5577, 2'h0}, '{0, 4'h2, 32'h0, 4'h0, 32'h0, 2'h2},
        '{1, 4'h2, 32'h1, 4'h3, 32'h0, 2'h2}, '{1, 4'hc, 32'h1, 4'h3, 32'h0, 2'h0},
        '{0, 4'h0, 32'h0, 4'h0, 32'hc141, 2'h0}};
    pdio_port i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .strap, .ext_in,
        .ext_data_out, .out_data_valid_pulse, .data_taken_pulse, .relay1, .relay2,
        .input_irq, .output_irq, .input_irq_ack, .output_irq_ack,
        .slave_response_enable, .input_read_strobe);
    pdio_ext_model i_ext (.aclk, .ext_data_out, .out_data_valid_pulse, .ext_in);
    always #2 aclk = ~aclk;
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one axi4-lite write or read; answer sampled just before the taking edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        logic aw, wd, ar, done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (n = 0; n < 64; n++)
        begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            wd = s_axi_wvalid & s_axi_wready;
            ar = s_axi_arvalid & s_axi_arready;
            done = w ? s_axi_bvalid : s_axi_rvalid;
            rv = s_axi_rdata;
            rr = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
            if (ar) s_axi_arvalid <= 1'b0;
            if (done) break;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (n == 64)
        begin
            err_count++;
            conclude;
        end
        // let a handshake pulse run out before the next one starts
        if ((a == 4'h4 && !w) || (a == 4'h8 && w)) repeat (256) @(posedge aclk);
    endtask
    task automatic rst(input logic [15:0] st, input logic [1:0] tl);
        @(posedge aclk);
        aresetn <= 1'b0;
        strap <= {st, tl};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic ack(input logic o);
        @(posedge aclk);
        output_irq_ack <= o;
        input_irq_ack <= !o;
        @(posedge aclk);
        output_irq_ack <= 1'b0;
        input_irq_ack <= 1'b0;
        @(negedge aclk);
    endtask
    task automatic feed(input logic [15:0] w, input logic s, input logic [31:0] irq);
        i_ext.send(w, s);
        repeat (3) @(negedge aclk);
        chk(32'(input_irq), irq);
    endtask
    // table cases, then output handshake, input modes and reset
    initial
    begin
        rst(16'hffff, 2'h0);
        foreach (rows[i])
        begin
            bus(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
            chk(32'(rr), 32'(rows[i].r));
            if (!rows[i].w) chk(rv, rows[i].e);
        end
        chk({30'h0, relay2, relay1}, 32'h3);
        chk({16'h0, i_ext.got}, 32'h5577);
        chk(32'(output_irq), 32'h1);
        ack(1'b1);
        chk(32'(output_irq), 32'h0);
        feed(16'h8003, 1'b0, 32'h1);
        bus(0, 4'h4, 32'h0, 4'h0);
        chk(rv, 32'h8003);
        bus(0, 4'h0, 32'h0, 4'h0);
        chk(rv, 32'hc1c1);
        ack(1'b0);
        chk(32'(input_irq), 32'h0);
        bus(1, 4'h4, 32'h1, 4'h1);
        bus(1, 4'h4, 32'h8000, 4'h1);
        bus(0, 4'h4, 32'h0, 4'h0);
        chk(rv, 32'h8002);
        rst(16'h0100, 2'h0);
        bus(1, 4'h0, 32'h40, 4'h1);
        feed(16'h0001, 1'b0, 32'h0);
        feed(16'h0100, 1'b0, 32'h1);
        rst(16'h0000, 2'h0);
        bus(1, 4'h0, 32'h40, 4'h1);
        feed(16'h0002, 1'b0, 32'h0);
        feed(16'h0000, 1'b1, 32'h1);
        rst(16'hffff, 2'h2);
        feed(16'hc000, 1'b0, 32'h0);
        bus(0, 4'h4, 32'h0, 4'h0);
        chk(rv, 32'hc000);
        rst(16'h0000, 2'h0);
        for (int i = 0; i < 3; i++)
        begin
            bus(0, 4'(4 * i), 32'h0, 4'h0);
            chk(rv, 32'h0);
        end
        conclude;
    end
endmodule
`default_nettype wire
